/* File: logic/aur_uart.sv */
// Asynchronous serial port with AHB-Lite register access.
`timescale 1ns/1ps
module aur_uart (
  // Clock, reset and clock enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [aur_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [aur_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [aur_pkg::DATA_W-1:0] hrdata,
  // Serial pins.
  input wire logic serial_input_pin,
  output logic serial_output_pin,
  output logic serial_output_oe,
  // Interrupt request.
  output logic irq
);
  import aur_pkg::*;
  // Bus front end: one wait state for every transfer.
  logic pend;
  logic wr_q;
  logic map_q;
  logic [7:0] idx_q;
  wire accept = hsel && htrans[1] && hready && !pend;
  wire addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  wire do_wr = ce && pend && wr_q && map_q;
  wire do_rd = ce && pend && !wr_q;
  wire [7:0] wd = hwdata[7:0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      wr_q <= 1'b0;
      map_q <= 1'b0;
      idx_q <= 8'h00;
    end else if (ce) begin
      pend <= accept;
      if (accept) begin
        wr_q <= hwrite;
        map_q <= addr_ok;
        idx_q <= haddr[9:2];
      end
    end
  end

  assign hreadyout = !pend;
  assign hresp = 1'b0;
  wire wr_intc = do_wr && idx_q == IX_INTERRUPT_CONTROL;
  wire wr_receive_status_control = do_wr && idx_q == IX_RECEIVE_STATUS_CONTROL;
  wire wr_txbuf = do_wr && idx_q == IX_TRANSMIT_BUFFER;
  wire wr_pie = do_wr && idx_q == IX_PERIPHERAL_IRQ_ENABLES;
  wire wr_transmit_status_control = do_wr && idx_q == IX_TRANSMIT_STATUS_CONTROL;
  wire wr_brg = do_wr && idx_q == IX_BAUD_DIVISOR;
  wire rd_fifo = do_rd && map_q && idx_q == IX_RECEIVE_FIFO;
  // Software control bits.
  logic global_irq_enable;
  logic peripheral_irq_enable;
  logic [7:0] peripheral_irq_enables;
  logic serial_port_on;
  logic nine_bit_receive_select;
  logic single_receive;
  logic continuous_receive_enable;
  logic clock_source;
  logic nine_bit_send_select;
  logic send_enable;
  logic sync_mode;
  logic high_speed_baud_select;
  logic send_ninth_bit;
  logic [7:0] baud_divisor;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_irq_enable <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      peripheral_irq_enables <= RST_PERIPHERAL_IRQ_ENABLES;
      baud_divisor <= RST_BAUD_DIVISOR;
    end else begin
      if (wr_intc) begin
        global_irq_enable <= wd[POS_GLOBAL_IRQ_ENABLE];
        peripheral_irq_enable <= wd[POS_PERIPHERAL_IRQ_ENABLE];
      end
      if (wr_pie) peripheral_irq_enables <= wd;
      if (wr_brg) baud_divisor <= wd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_port_on <= RST_ZERO[POS_SERIAL_PORT_ON];
      nine_bit_receive_select <= RST_ZERO[POS_NINE_BIT_RECEIVE];
      single_receive <= RST_ZERO[POS_SINGLE_RECEIVE];
      continuous_receive_enable <= RST_ZERO[POS_CONTINUOUS_RECEIVE];
    end else if (wr_receive_status_control) begin
      serial_port_on <= wd[POS_SERIAL_PORT_ON];
      nine_bit_receive_select <= wd[POS_NINE_BIT_RECEIVE];
      single_receive <= wd[POS_SINGLE_RECEIVE];
      continuous_receive_enable <= wd[POS_CONTINUOUS_RECEIVE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_source <= RST_TRANSMIT_STATUS_CONTROL[POS_CLOCK_SOURCE];
      nine_bit_send_select <= RST_TRANSMIT_STATUS_CONTROL[POS_NINE_BIT_SEND];
      send_enable <= RST_TRANSMIT_STATUS_CONTROL[POS_SEND_ENABLE];
      sync_mode <= RST_TRANSMIT_STATUS_CONTROL[POS_SYNC_MODE];
      high_speed_baud_select <= RST_TRANSMIT_STATUS_CONTROL[POS_HIGH_SPEED_BAUD];
      send_ninth_bit <= RST_TRANSMIT_STATUS_CONTROL[POS_SEND_NINTH];
    end else if (wr_transmit_status_control) begin
      clock_source <= wd[POS_CLOCK_SOURCE];
      nine_bit_send_select <= wd[POS_NINE_BIT_SEND];
      send_enable <= wd[POS_SEND_ENABLE];
      sync_mode <= wd[POS_SYNC_MODE];
      high_speed_baud_select <= wd[POS_HIGH_SPEED_BAUD];
      send_ninth_bit <= wd[POS_SEND_NINTH];
    end
  end
  // Mode selection.
  wire async_on = serial_port_on && !sync_mode;
  wire rx_on = async_on && continuous_receive_enable;
  wire tx_on = async_on && send_enable;
  // Baud generator: reloading down-counter, then a divide by four at low speed.
  logic [7:0] brg_cnt;
  logic [1:0] brg_pre;
  wire brg_run = async_on && (send_enable || continuous_receive_enable);
  wire brg_tick = brg_run && brg_cnt == 8'h00;
  wire samp_tick = brg_tick && (high_speed_baud_select || brg_pre == LOW_SPEED_PRESCALE_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brg_cnt <= 8'h00;
      brg_pre <= 2'h0;
    end else if (ce) begin
      if (!brg_run) begin
        brg_cnt <= baud_divisor;
        brg_pre <= 2'h0;
      end else if (brg_tick) begin
        brg_cnt <= baud_divisor;
        brg_pre <= brg_pre + 2'h1;
      end else begin
        brg_cnt <= brg_cnt - 8'h01;
      end
    end
  end
  // Receive pin synchroniser and data recovery.
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  aur_rx_state_t rx_state;
  logic [3:0] rx_cnt;
  logic [3:0] rx_bits;
  logic [8:0] receive_shifter;
  wire rx_fall = rx_prev && !rx_sync;
  wire rx_mid = samp_tick && rx_cnt == SAMPLE_MID;
  wire rx_end = samp_tick && rx_cnt == SAMPLE_LAST;
  wire [3:0] rx_nbits = nine_bit_receive_select ? DATA_BITS_9 : DATA_BITS_8;
  wire rx_shift = ce && rx_on && rx_state == RX_DATA && rx_end;
  wire stop_ev = ce && rx_on && rx_state == RX_STOP && rx_end;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else if (ce) begin
      rx_meta <= serial_input_pin;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 4'h0;
      rx_bits <= 4'h0;
      receive_shifter <= 9'h000;
    end else if (ce) begin
      if (!rx_on) begin
        rx_state <= RX_IDLE;
      end else begin
        if (samp_tick) rx_cnt <= rx_cnt + 4'h1;
        case (rx_state)
          RX_IDLE: begin
            if (rx_fall) begin
              rx_state <= RX_START;
              rx_cnt <= 4'h0;
            end
          end
          RX_START: begin
            if (rx_mid) begin
              rx_state <= rx_sync ? RX_IDLE : RX_DATA;
              rx_cnt <= 4'h0;
              rx_bits <= 4'h0;
            end
          end
          RX_DATA: begin
            if (rx_end) begin
              receive_shifter <= {rx_sync, receive_shifter[8:1]};
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits == rx_nbits - 4'h1) rx_state <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_end) rx_state <= RX_IDLE;
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end
  // Receive FIFO: data, framing error and ninth bit per entry.
  logic overrun_flag;
  logic [9:0] fifo_mem [0:1];
  logic fifo_wp;
  logic fifo_rp;
  logic [1:0] fifo_count;
  wire fifo_full = fifo_count == FIFO_FULL;
  wire pop = rd_fifo && fifo_count != 2'h0;
  wire push = stop_ev && !overrun_flag && !fifo_full;
  wire ovr_set = stop_ev && !overrun_flag && fifo_full;
  wire [7:0] rx_byte = nine_bit_receive_select ? receive_shifter[7:0] : receive_shifter[8:1];
  wire rx_ninth = nine_bit_receive_select && receive_shifter[8];
  wire [9:0] entry = {!rx_sync, rx_ninth, rx_byte};
  wire [9:0] head = fifo_mem[fifo_rp];
  wire receive_ready_flag = fifo_count != 2'h0;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_fifo
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) fifo_mem[gi] <= 10'h000;
        else if (push && fifo_wp == 1'(gi)) fifo_mem[gi] <= entry;
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_wp <= 1'b0;
      fifo_rp <= 1'b0;
      fifo_count <= 2'h0;
      overrun_flag <= 1'b0;
    end else if (ce) begin
      if (push) fifo_wp <= !fifo_wp;
      if (pop) fifo_rp <= !fifo_rp;
      fifo_count <= fifo_count + {1'b0, push} - {1'b0, pop};
      overrun_flag <= rx_on && (overrun_flag || ovr_set);
    end
  end
  // Transmitter.
  logic [7:0] send_buffer;
  logic buf_full;
  logic send_buffer_empty_flag;
  logic [10:0] send_shifter;
  logic [3:0] tx_left;
  logic [3:0] tx_cnt;
  wire shifter_empty_status = tx_left == 4'h0;
  wire tx_load = ce && tx_on && buf_full && shifter_empty_status;
  wire send_enable_rise = wr_transmit_status_control && wd[POS_SEND_ENABLE] && !send_enable;
  wire tx_ninth = nine_bit_send_select ? send_ninth_bit : 1'b1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_buffer <= RST_ZERO;
      buf_full <= 1'b0;
      send_buffer_empty_flag <= 1'b0;
    end else if (ce) begin
      if (wr_txbuf) send_buffer <= wd;
      buf_full <= wr_txbuf || (buf_full && !tx_load);
      if (wr_txbuf) send_buffer_empty_flag <= 1'b0;
      else if (tx_load || send_enable_rise) send_buffer_empty_flag <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_shifter <= 11'h7FF;
      tx_left <= 4'h0;
      tx_cnt <= 4'h0;
    end else if (ce) begin
      if (!tx_on) begin
        send_shifter <= 11'h7FF;
        tx_left <= 4'h0;
        tx_cnt <= 4'h0;
      end else if (tx_load) begin
        send_shifter <= {1'b1, tx_ninth, send_buffer, 1'b0};
        tx_left <= nine_bit_send_select ? FRAME_BITS_9 : FRAME_BITS_8;
        tx_cnt <= 4'h0;
      end else if (samp_tick && !shifter_empty_status) begin
        tx_cnt <= tx_cnt + 4'h1;
        if (tx_cnt == SAMPLE_LAST) begin
          send_shifter <= {1'b1, send_shifter[10:1]};
          tx_left <= tx_left - 4'h1;
        end
      end
    end
  end

  assign serial_output_pin = send_shifter[0];
  assign serial_output_oe = tx_on;
  // Read data and interrupt output.
  wire [7:0] intc_rd = {global_irq_enable, peripheral_irq_enable, 6'h00};
  wire [7:0] pir_rd = {2'h0, receive_ready_flag, send_buffer_empty_flag, 4'h0};
  wire [7:0] receive_status_control_rd = {serial_port_on, nine_bit_receive_select, single_receive,
    continuous_receive_enable, 1'b0, head[9] && receive_ready_flag, overrun_flag,
    head[8] && receive_ready_flag};
  wire [7:0] transmit_status_control_rd = {clock_source, nine_bit_send_select, send_enable, sync_mode,
    1'b0, high_speed_baud_select, shifter_empty_status, send_ninth_bit};
  wire [7:0] rd_mux = !map_q ? 8'h00 :
    idx_q == IX_INTERRUPT_CONTROL ? intc_rd :
    idx_q == IX_PERIPHERAL_IRQ_FLAGS ? pir_rd :
    idx_q == IX_RECEIVE_STATUS_CONTROL ? receive_status_control_rd :
    idx_q == IX_TRANSMIT_BUFFER ? send_buffer :
    idx_q == IX_RECEIVE_FIFO ? head[7:0] :
    idx_q == IX_PERIPHERAL_IRQ_ENABLES ? peripheral_irq_enables :
    idx_q == IX_TRANSMIT_STATUS_CONTROL ? transmit_status_control_rd :
    idx_q == IX_BAUD_DIVISOR ? baud_divisor : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h00000000;
    else if (do_rd) hrdata <= {24'h000000, rd_mux};
  end

  wire rx_req = receive_ready_flag && peripheral_irq_enables[POS_RECEIVE_IRQ_ENABLE];
  wire tx_req = send_buffer_empty_flag && peripheral_irq_enables[POS_SEND_IRQ_ENABLE];
  assign irq = global_irq_enable && peripheral_irq_enable && (rx_req || tx_req);
  // Checks.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_irq_needs_gates: assert property (irq |-> global_irq_enable && peripheral_irq_enable)
    else $error("irq without global and peripheral enables");
  a_rx_irq_enable: assert property (irq && !tx_req |->
    peripheral_irq_enables[POS_RECEIVE_IRQ_ENABLE] && receive_ready_flag)
    else $error("receive interrupt without its enable");
  a_tx_irq_enable: assert property (irq && !rx_req |->
    peripheral_irq_enables[POS_SEND_IRQ_ENABLE])
    else $error("send interrupt without its enable");
  a_ready_clears: assert property (pop && fifo_count == 2'h1 && !push |=> !receive_ready_flag)
    else $error("ready flag stayed after last read");
  a_push_sets: assert property (push && !pop |=> receive_ready_flag ##0
    fifo_count == $past(fifo_count) + 2'h1)
    else $error("stored word did not raise ready");
  a_overrun_set: assert property (stop_ev && fifo_full && rx_on |=> overrun_flag)
    else $error("overrun not flagged on full fifo");
  a_overrun_blocks: assert property (overrun_flag |-> !push)
    else $error("word stored while overrun set");
  a_rx_off_idle: assert property (ce && !rx_on |=> rx_state == RX_IDLE && !overrun_flag)
    else $error("receiver active while disabled");
  a_shift_per_bit: assert property (rx_shift |-> samp_tick && rx_cnt == SAMPLE_LAST)
    else $error("receive shift off bit boundary");
  a_send_enable_flag: assert property (send_enable_rise && ce |=> send_buffer_empty_flag)
    else $error("send enable did not set empty flag");
  a_tx_start: assert property (wr_txbuf && ce && tx_on && shifter_empty_status && !wr_transmit_status_control
    |=> ##[0:1] !shifter_empty_status)
    else $error("buffer write did not start sending");
  a_reserved_zero: assert property (do_rd && map_q && idx_q == IX_RECEIVE_STATUS_CONTROL
    |=> hrdata[3] == 1'b0)
    else $error("unimplemented bit read as one");
  a_bus_wait: assert property (accept && ce |=> !hreadyout ##1 (hreadyout || !$past(ce)))
    else $error("bus wait state wrong");
endmodule : aur_uart

/* File: shared/aur_pkg.sv */
// Register map, field positions, reset values and counts for the serial port.
package aur_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IX_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] IX_PERIPHERAL_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] IX_RECEIVE_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] IX_TRANSMIT_BUFFER = 8'h19;
  localparam logic [7:0] IX_RECEIVE_FIFO = 8'h1A;
  localparam logic [7:0] IX_PERIPHERAL_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] IX_TRANSMIT_STATUS_CONTROL = 8'h98;
  localparam logic [7:0] IX_BAUD_DIVISOR = 8'h99;
  // Field positions.
  localparam int POS_GLOBAL_IRQ_ENABLE = 7;
  localparam int POS_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int POS_RECEIVE_READY = 5;
  localparam int POS_SEND_BUFFER_EMPTY = 4;
  localparam int POS_RECEIVE_IRQ_ENABLE = 5;
  localparam int POS_SEND_IRQ_ENABLE = 4;
  localparam int POS_SERIAL_PORT_ON = 7;
  localparam int POS_NINE_BIT_RECEIVE = 6;
  localparam int POS_SINGLE_RECEIVE = 5;
  localparam int POS_CONTINUOUS_RECEIVE = 4;
  localparam int POS_FRAMING_ERROR = 2;
  localparam int POS_OVERRUN = 1;
  localparam int POS_RECEIVED_NINTH = 0;
  localparam int POS_CLOCK_SOURCE = 7;
  localparam int POS_NINE_BIT_SEND = 6;
  localparam int POS_SEND_ENABLE = 5;
  localparam int POS_SYNC_MODE = 4;
  localparam int POS_HIGH_SPEED_BAUD = 2;
  localparam int POS_SHIFTER_EMPTY = 1;
  localparam int POS_SEND_NINTH = 0;
  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;
  // Counts.
  localparam logic [1:0] LOW_SPEED_PRESCALE_LAST = 2'h3;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'hF;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } aur_rx_state_t;
endpackage : aur_pkg

/* File: testbench/aur_serial_peer.sv */
// Remote asynchronous serial device: frame sender and receive-line monitor.
`timescale 1ns/1ps
module aur_serial_peer (
  // Clock.
  input wire logic hclk,
  // Serial lines.
  input wire logic line_in,
  output logic line_out
);
  int bit_clks = 16;
  int nbits = 8;
  int rx_count = 0;
  logic [8:0] rx_word = 9'h000;

  initial line_out = 1'b1;

  // Sends one frame, then one idle bit so the receiver can rearm.
  task automatic send(input logic [8:0] w, input logic stop);
    @(posedge hclk);
    line_out <= 1'b0;
    repeat (bit_clks) @(posedge hclk);
    for (int i = 0; i < nbits; i++) begin
      line_out <= w[i];
      repeat (bit_clks) @(posedge hclk);
    end
    line_out <= stop;
    repeat (bit_clks) @(posedge hclk);
    line_out <= 1'b1;
    repeat (bit_clks) @(posedge hclk);
  endtask : send

  // Samples each bit at its centre; counts only frames with a good stop bit.
  always begin : watch
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge hclk);
    if (line_in === 1'b0) begin
      rx_word = 9'h000;
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_clks) @(posedge hclk);
        rx_word[i] = line_in;
      end
      repeat (bit_clks) @(posedge hclk);
      if (line_in === 1'b1) begin
        rx_count++;
      end
    end
  end
endmodule : aur_serial_peer

/* File: testbench/tb_async_uart_rx_tx.sv */
// Self-checking bench for the serial port: registers, transmit and receive paths.
`timescale 1ns/1ps
module tb_async_uart_rx_tx;
  import aur_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [ADDR_W-1:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [DATA_W-1:0] hwdata = '0;
  logic [7:0] rd;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [DATA_W-1:0] hrdata;
  wire logic rx_line;
  wire logic pin;
  wire logic oe;
  wire logic irq;
  wire logic tx_line;
  int n_mismatch = 0;
  int checks_done = 0;

  // The transmit line has a pull-up while the port does not drive it.
  assign tx_line = oe ? pin : 1'b1;

  aur_uart uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_input_pin(rx_line),
    .serial_output_pin(pin), .serial_output_oe(oe), .irq(irq));
  aur_serial_peer peer (.hclk(hclk), .line_in(tx_line), .line_out(rx_line));

  initial begin
    forever #12.5 hclk = ~hclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang(input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      $display("MISMATCH t=%0t wait ran out", $time);
      wrap_up();
    end
  endtask : hang

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hang(n, 50);
  endtask : wait_ready

  task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, ix, 2'h0};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata[7:0];
    chk({8'h00, hresp}, 9'h000);
  endtask : bus

  task automatic rdchk(input logic [7:0] ix, input logic [7:0] exp);
    bus(1'b0, ix, 8'h00);
    chk({1'b0, rd}, {1'b0, exp});
  endtask : rdchk

  task automatic tx_wait(input int c);
    int n;
    n = 0;
    while (peer.rx_count != c && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    hang(n, 3000);
  endtask : tx_wait

  task automatic t_reset();
    logic [7:0] ix [9];
    ix = '{IX_INTERRUPT_CONTROL, IX_PERIPHERAL_IRQ_FLAGS, IX_RECEIVE_STATUS_CONTROL,
      IX_TRANSMIT_BUFFER, IX_RECEIVE_FIFO, IX_PERIPHERAL_IRQ_ENABLES,
      IX_TRANSMIT_STATUS_CONTROL, IX_BAUD_DIVISOR, 8'hFF};
    for (int i = 0; i < 9; i++) begin
      rdchk(ix[i], ix[i] == IX_TRANSMIT_STATUS_CONTROL ? RST_TRANSMIT_STATUS_CONTROL : 8'h00);
    end
    bus(1'b1, IX_PERIPHERAL_IRQ_FLAGS, 8'hFF);
    rdchk(IX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_tx();
    bus(1'b1, IX_RECEIVE_STATUS_CONTROL, 8'h80);
    bus(1'b1, IX_TRANSMIT_STATUS_CONTROL, 8'h24);
    rdchk(IX_PERIPHERAL_IRQ_FLAGS, 8'h10);
    bus(1'b1, IX_TRANSMIT_BUFFER, 8'hA5);
    rdchk(IX_TRANSMIT_STATUS_CONTROL, 8'h24);
    tx_wait(1);
    chk(peer.rx_word, 9'h0A5);
    repeat (16) @(posedge hclk);
    rdchk(IX_TRANSMIT_STATUS_CONTROL, 8'h26);
    peer.nbits = 9;
    bus(1'b1, IX_TRANSMIT_STATUS_CONTROL, 8'h65);
    chk({8'h00, oe}, 9'h001);
    bus(1'b1, IX_TRANSMIT_BUFFER, 8'h3C);
    tx_wait(2);
    chk(peer.rx_word, 9'h13C);
    bus(1'b1, IX_PERIPHERAL_IRQ_ENABLES, 8'h10);
    bus(1'b1, IX_INTERRUPT_CONTROL, 8'h80);
    chk({8'h00, irq}, 9'h000);
    bus(1'b1, IX_INTERRUPT_CONTROL, 8'hC0);
    chk({8'h00, irq}, 9'h001);
    bus(1'b1, IX_PERIPHERAL_IRQ_ENABLES, 8'h00);
    chk({8'h00, irq}, 9'h000);
    peer.nbits = 8;
    bus(1'b1, IX_TRANSMIT_STATUS_CONTROL, 8'h34);
    chk({8'h00, oe}, 9'h000);
    bus(1'b1, IX_TRANSMIT_STATUS_CONTROL, 8'h04);
    $display("test transmit done");
  endtask : t_tx

  task automatic t_rx();
    bus(1'b1, IX_PERIPHERAL_IRQ_ENABLES, 8'h20);
    bus(1'b1, IX_RECEIVE_STATUS_CONTROL, 8'h90);
    peer.send(9'h05A, 1'b1);
    rdchk(IX_PERIPHERAL_IRQ_FLAGS, 8'h30);
    chk({8'h00, irq}, 9'h001);
    peer.send(9'h0C3, 1'b0);
    peer.send(9'h077, 1'b1);
    rdchk(IX_RECEIVE_STATUS_CONTROL, 8'h92);
    rdchk(IX_RECEIVE_FIFO, 8'h5A);
    rdchk(IX_RECEIVE_STATUS_CONTROL, 8'h96);
    rdchk(IX_RECEIVE_FIFO, 8'hC3);
    rdchk(IX_PERIPHERAL_IRQ_FLAGS, 8'h10);
    peer.send(9'h011, 1'b1);
    rdchk(IX_PERIPHERAL_IRQ_FLAGS, 8'h10);
    bus(1'b1, IX_RECEIVE_STATUS_CONTROL, 8'h90);
    rdchk(IX_RECEIVE_STATUS_CONTROL, 8'h92);
    bus(1'b1, IX_RECEIVE_STATUS_CONTROL, 8'h80);
    peer.send(9'h044, 1'b1);
    rdchk(IX_PERIPHERAL_IRQ_FLAGS, 8'h10);
    bus(1'b1, IX_RECEIVE_STATUS_CONTROL, 8'h98);
    rdchk(IX_RECEIVE_STATUS_CONTROL, 8'h90);
    peer.send(9'h066, 1'b1);
    rdchk(IX_RECEIVE_FIFO, 8'h66);
    peer.nbits = 9;
    bus(1'b1, IX_RECEIVE_STATUS_CONTROL, 8'hD0);
    peer.send(9'h1A5, 1'b1);
    rdchk(IX_RECEIVE_STATUS_CONTROL, 8'hD1);
    rdchk(IX_RECEIVE_FIFO, 8'hA5);
    peer.nbits = 8;
    $display("test receive done");
  endtask : t_rx

  task automatic t_rates();
    bus(1'b1, IX_RECEIVE_STATUS_CONTROL, 8'h90);
    bus(1'b1, IX_BAUD_DIVISOR, 8'h01);
    peer.bit_clks = 32;
    peer.send(9'h069, 1'b1);
    rdchk(IX_RECEIVE_FIFO, 8'h69);
    bus(1'b1, IX_BAUD_DIVISOR, 8'h00);
    bus(1'b1, IX_TRANSMIT_STATUS_CONTROL, 8'h00);
    peer.bit_clks = 64;
    peer.send(9'h096, 1'b1);
    rdchk(IX_RECEIVE_FIFO, 8'h96);
    $display("test rates done");
  endtask : t_rates

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_tx();
    t_rx();
    t_rates();
    wrap_up();
  end
endmodule : tb_async_uart_rx_tx
